/* dcf_defines.vh */
// constants for the fifo latency and flag block
`ifndef DCF_DEFINES_VH
`define DCF_DEFINES_VH

// ************************************
// storage geometry
// ************************************
`define DCF_DW            36
`define DCF_AW            6
`define DCF_PW            7
`define DCF_DEPTH         7'h40
`define DCF_HIST          8

// ************************************
// latencies in cycles
// ************************************
`define DCF_L_FF_ASSERT   4
`define DCF_L_EF_ASSERT   0
`define DCF_L_PRS_ACTIVE  6'h20
`define DCF_L_MAILBOX     2
`define DCF_L_REN_DATA    4
`define DCF_L_REN_CFG     4
`define DCF_L_WR_PAE      5
`define DCF_L_WR_PAF      5
`define DCF_L_RD_PAE      7
`define DCF_L_RD_PAF      7
`define DCF_L_FF_DEASSERT 8
`define DCF_L_RT_REN      5'h11
`define DCF_L_RT_DATA     21
`define DCF_L_IN          26
`define DCF_L_EF_DEASSERT 24
`define DCF_L_FF_RELEASE  6

// ************************************
// register map and reset values
// ************************************
`define DCF_REG_STATUS    8'h00
`define DCF_REG_IRQ_CLR   8'h04
`define DCF_REG_IRQ_EN    8'h08
`define DCF_REG_AE_OFF    8'h0C
`define DCF_REG_AF_OFF    8'h10
`define DCF_REG_LEVEL     8'h14
`define DCF_AE_OFF_RST    7'h08
`define DCF_AF_OFF_RST    7'h08
`define DCF_IRQ_EN_RST    6'h00

// ************************************
// status bits
// ************************************
`define DCF_NEV           6
`define DCF_EV_FULL       0
`define DCF_EV_EMPTY      1
`define DCF_EV_AE         2
`define DCF_EV_AF         3
`define DCF_EV_OVF        4
`define DCF_EV_UNF        5

`endif

/* dcf_fifo.v */
// fifo core with latency-shaped flags, mailbox, retransmit and register port
`include "dcf_defines.vh"

module dcf_fifo (
	// clock and reset
	input  wire                    clk,
	input  wire                    rst_b,
	// write port
	input  wire                    wr_en_n,
	input  wire [`DCF_DW-1:0]      wr_data,
	input  wire                    mailbox_select,
	// read port
	input  wire                    rd_en_n,
	input  wire                    config_load_select_n,
	input  wire                    retransmit_request_n,
	input  wire                    mark_req,
	output reg  [`DCF_DW-1:0]      q_r,
	output reg                     q_valid_r,
	// flags
	output reg                     full_flag_n,
	output reg                     empty_flag_n,
	output reg                     almost_empty_flag_n,
	output reg                     almost_full_flag_n,
	// partial reset
	input  wire                    partial_reset_n,
	output reg                     busy_r,
	// register port
	input  wire [7:0]              reg_addr,
	input  wire [31:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [31:0]             reg_rdata_r,
	// interrupt
	output reg                     irq_r
);

	// ************************************
	// helpers
	// ************************************
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// ************************************
	// storage and pointers
	// ************************************
	reg  [`DCF_DW-1:0]  mem [0:(1<<`DCF_AW)-1];
	reg  [`DCF_PW-1:0]  wr_ptr_r;
	reg  [`DCF_PW-1:0]  rd_ptr_r;
	reg  [`DCF_PW-1:0]  rd_ptr_nxt;
	reg  [`DCF_PW-1:0]  mark_ptr_r;
	reg                 mark_vld_r;
	reg                 rt_mode_r;
	reg                 rt_prev_r;
	reg  [4:0]          rt_cnt_r;
	reg  [5:0]          prs_cnt_r;
	reg  [6:0]          ae_off_r;
	reg  [6:0]          af_off_r;
	reg  [`DCF_NEV-1:0] irq_st_r;
	reg  [`DCF_NEV-1:0] irq_en_r;
	reg                 cfg_idx_r;

	// ************************************
	// read data pipeline
	// ************************************
	reg  [`DCF_DW-1:0]  p1_dat_r;
	reg  [`DCF_DW-1:0]  p2_dat_r;
	reg  [`DCF_DW-1:0]  p3_dat_r;
	reg                 p1_vld_r;
	reg                 p2_vld_r;
	reg                 p3_vld_r;
	reg  [`DCF_DW-1:0]  mb_dat_r;
	reg                 mb_vld_r;

	// ************************************
	// request decode
	// ************************************
	wire                active;
	wire [`DCF_PW-1:0]  rel_ptr;
	wire [`DCF_PW-1:0]  lvl_real;
	wire [`DCF_PW-1:0]  space_used;
	wire                room;
	wire                data_avail;
	wire                rt_fall;
	wire                rt_wait;
	wire                wr_try;
	wire                rd_try;
	wire                wr_go;
	wire                mb_go;
	wire                rd_go;
	wire                cfg_go;
	wire                rt_go;
	wire                drain;

	// no fifo read, write, mark or retransmit takes effect until the post-reset settling count ends
	assign active     = ~busy_r;
	// while a mark stands the marked words must survive, so space counts from it
	assign rel_ptr    = mark_vld_r ? mark_ptr_r : rd_ptr_r;
	assign lvl_real   = wr_ptr_r - rd_ptr_r;
	assign space_used = wr_ptr_r - rel_ptr;
	assign room       = (space_used != `DCF_DEPTH);
	assign data_avail = (lvl_real != 7'h00);
	assign rt_fall    = rt_prev_r & ~retransmit_request_n;
	assign rt_wait    = (rt_cnt_r != 5'h00);
	assign wr_try     = ~wr_en_n & ~mailbox_select & active;
	assign rd_try     = ~rd_en_n & config_load_select_n & active;
	assign wr_go      = wr_try & room;
	assign mb_go      = ~wr_en_n & mailbox_select & active;
	assign rd_go      = rd_try & data_avail & ~rt_wait;
	assign cfg_go     = ~rd_en_n & ~config_load_select_n & active;
	assign rt_go      = rt_fall & mark_vld_r & active;
	// a retransmit pass ends on the read that empties the fifo
	assign drain      = rt_mode_r & rd_go & (rd_ptr_nxt == wr_ptr_r);

	always @* begin
		rd_ptr_nxt = rd_ptr_r;
		if (rt_go) begin
			rd_ptr_nxt = mark_ptr_r;
		end else if (rd_go) begin
			rd_ptr_nxt = rd_ptr_r + 7'h01;
		end
	end

	// ************************************
	// pointer history for flag latency
	// ************************************
	// each flag looks at pointers of a set age, index k gives k+1 cycles of latency
	wire [`DCF_PW-1:0]  wh [0:`DCF_HIST-1];
	wire [`DCF_PW-1:0]  rh [0:`DCF_HIST-1];
	wire [`DCF_PW-1:0]  dh [0:`DCF_HIST-1];

	assign wh[0] = wr_ptr_r;
	assign rh[0] = rel_ptr;
	assign dh[0] = rd_ptr_r;

	genvar gi;
	generate
		for (gi = 1; gi < `DCF_HIST; gi = gi + 1) begin : g_hist
			reg [`DCF_PW-1:0] wh_r;
			reg [`DCF_PW-1:0] rh_r;
			reg [`DCF_PW-1:0] dh_r;
			assign wh[gi] = wh_r;
			assign rh[gi] = rh_r;
			assign dh[gi] = dh_r;
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					wh_r <= 7'h00;
					rh_r <= 7'h00;
					dh_r <= 7'h00;
				end else begin
					wh_r <= wh[gi-1];
					dh_r <= dh[gi-1];
					// end of retransmit frees the held words at once
					if (drain) begin
						rh_r <= rd_ptr_nxt;
					end else begin
						rh_r <= rh[gi-1];
					end
				end
			end
		end
	endgenerate

	// ************************************
	// flag levels
	// ************************************
	wire [`DCF_PW-1:0]  lvl_full;
	wire [`DCF_PW-1:0]  lvl_ae;
	wire [`DCF_PW-1:0]  lvl_af;
	wire [`DCF_PW-1:0]  af_bound;
	wire                full_nxt;
	wire                empty_nxt;
	wire                ae_nxt;
	wire                af_nxt;

	// write side seen after 1 cycle, read side after 8
	assign lvl_full  = wh[0] - (drain ? rd_ptr_nxt : rh[`DCF_L_FF_DEASSERT-1]);
	// write side after 5 cycles, read side after 7
	assign lvl_ae    = wh[`DCF_L_WR_PAE-1] - dh[`DCF_L_RD_PAE-1];
	assign lvl_af    = wh[`DCF_L_WR_PAF-1] - rh[`DCF_L_RD_PAF-1];
	assign af_bound  = `DCF_DEPTH - af_off_r;
	assign full_nxt  = (lvl_full == `DCF_DEPTH);
	// read side taken at its next value, so the flag drops on the read edge
	assign empty_nxt = (wh[0] == rd_ptr_nxt);
	assign ae_nxt    = (lvl_ae <= ae_off_r);
	assign af_nxt    = (lvl_af >= af_bound);

	// ************************************
	// flags, all active low and registered
	// ************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			full_flag_n         <= 1'b1;
			empty_flag_n        <= 1'b0;
			almost_empty_flag_n <= 1'b0;
			almost_full_flag_n  <= 1'b1;
		end else begin
			full_flag_n         <= ~full_nxt;
			empty_flag_n        <= ~empty_nxt;
			almost_empty_flag_n <= ~ae_nxt;
			almost_full_flag_n  <= ~af_nxt;
		end
	end

	// ************************************
	// partial reset and settle count
	// ************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_r    <= 1'b1;
			prs_cnt_r <= `DCF_L_PRS_ACTIVE;
		end else if (!partial_reset_n) begin
			busy_r    <= 1'b1;
			prs_cnt_r <= `DCF_L_PRS_ACTIVE;
		end else if (prs_cnt_r != 6'h00) begin
			prs_cnt_r <= prs_cnt_r - 6'h01;
			busy_r    <= (prs_cnt_r != 6'h01);
		end else begin
			busy_r    <= 1'b0;
		end
	end

	// ************************************
	// pointers, mark and retransmit
	// ************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_r   <= 7'h00;
			rd_ptr_r   <= 7'h00;
			mark_ptr_r <= 7'h00;
			mark_vld_r <= 1'b0;
			rt_mode_r  <= 1'b0;
			rt_prev_r  <= 1'b1;
			rt_cnt_r   <= 5'h00;
		end else if (!partial_reset_n) begin
			// data is dropped, settings stay
			wr_ptr_r   <= 7'h00;
			rd_ptr_r   <= 7'h00;
			mark_ptr_r <= 7'h00;
			mark_vld_r <= 1'b0;
			rt_mode_r  <= 1'b0;
			rt_prev_r  <= 1'b1;
			rt_cnt_r   <= 5'h00;
		end else begin
			rt_prev_r <= retransmit_request_n;
			if (wr_go) begin
				wr_ptr_r <= wr_ptr_r + 7'h01;
			end
			rd_ptr_r <= rd_ptr_nxt;
			if (rt_go) begin
				// reads are held off while the flags catch up with the old position
				rt_cnt_r  <= `DCF_L_RT_REN - 5'h01;
				rt_mode_r <= 1'b1;
			end else if (rt_wait) begin
				rt_cnt_r <= rt_cnt_r - 5'h01;
			end
			if (drain) begin
				rt_mode_r  <= 1'b0;
				mark_vld_r <= 1'b0;
			end else if (mark_req & ~rt_mode_r & active) begin
				mark_ptr_r <= rd_ptr_r;
				mark_vld_r <= 1'b1;
			end
		end
	end

	// ************************************
	// storage write, no reset on the array
	// ************************************
	always @(posedge clk) begin
		if (wr_go) begin
			mem[wr_ptr_r[`DCF_AW-1:0]] <= wr_data;
		end
	end

	// ************************************
	// read pipeline and mailbox path
	// ************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			p1_dat_r  <= {`DCF_DW{1'b0}};
			p2_dat_r  <= {`DCF_DW{1'b0}};
			p3_dat_r  <= {`DCF_DW{1'b0}};
			p1_vld_r  <= 1'b0;
			p2_vld_r  <= 1'b0;
			p3_vld_r  <= 1'b0;
			mb_dat_r  <= {`DCF_DW{1'b0}};
			mb_vld_r  <= 1'b0;
			q_r       <= {`DCF_DW{1'b0}};
			q_valid_r <= 1'b0;
			cfg_idx_r <= 1'b0;
		end else begin
			// three stages plus the output flop give four edges from read to data
			if (rd_go) begin
				p1_dat_r <= mem[rd_ptr_r[`DCF_AW-1:0]];
			end else if (cfg_go) begin
				p1_dat_r <= cfg_idx_r ? {29'h0000000, af_off_r} :
				            {29'h0000000, ae_off_r};
			end
			if (cfg_go) begin
				cfg_idx_r <= ~cfg_idx_r;
			end
			p1_vld_r <= rd_go | cfg_go;
			p2_dat_r <= p1_dat_r;
			p2_vld_r <= p1_vld_r;
			p3_dat_r <= p2_dat_r;
			p3_vld_r <= p2_vld_r;
			// mailbox bypasses storage: capture edge plus output edge
			mb_dat_r <= wr_data;
			mb_vld_r <= mb_go;
			// mailbox wins a collision; the pipeline word of that cycle is lost
			if (mb_vld_r) begin
				q_r <= mb_dat_r;
			end else if (p3_vld_r) begin
				q_r <= p3_dat_r;
			end
			q_valid_r <= mb_vld_r | p3_vld_r;
		end
	end

	// ************************************
	// interrupt events and status
	// ************************************
	wire [`DCF_NEV-1:0] ev;
	wire [`DCF_NEV-1:0] clr;
	wire [`DCF_NEV-1:0] irq_st_nxt;

	assign ev[`DCF_EV_FULL]  = full_flag_n & full_nxt;
	assign ev[`DCF_EV_EMPTY] = empty_flag_n & empty_nxt;
	assign ev[`DCF_EV_AE]    = almost_empty_flag_n & ae_nxt;
	assign ev[`DCF_EV_AF]    = almost_full_flag_n & af_nxt;
	assign ev[`DCF_EV_OVF]   = wr_try & ~room;
	assign ev[`DCF_EV_UNF]   = rd_try & (~data_avail | rt_wait);
	assign clr = (reg_wr & hit(reg_addr, `DCF_REG_IRQ_CLR)) ?
	             reg_wdata[`DCF_NEV-1:0] : {`DCF_NEV{1'b0}};
	// an event in the clearing cycle survives
	assign irq_st_nxt = (irq_st_r & ~clr) | ev;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_st_r <= {`DCF_NEV{1'b0}};
			irq_r    <= 1'b0;
		end else begin
			irq_st_r <= irq_st_nxt;
			irq_r    <= |(irq_st_nxt & irq_en_r);
		end
	end

	// ************************************
	// register port
	// ************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_en_r <= `DCF_IRQ_EN_RST;
			ae_off_r <= `DCF_AE_OFF_RST;
			af_off_r <= `DCF_AF_OFF_RST;
		end else if (reg_wr) begin
			if (hit(reg_addr, `DCF_REG_IRQ_EN)) begin
				irq_en_r <= reg_wdata[`DCF_NEV-1:0];
			end
			if (hit(reg_addr, `DCF_REG_AE_OFF)) begin
				ae_off_r <= reg_wdata[6:0];
			end
			if (hit(reg_addr, `DCF_REG_AF_OFF)) begin
				af_off_r <= reg_wdata[6:0];
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_r <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`DCF_REG_STATUS: begin
					reg_rdata_r <= {26'h0, irq_st_r};
				end
				`DCF_REG_IRQ_EN: begin
					reg_rdata_r <= {26'h0, irq_en_r};
				end
				`DCF_REG_AE_OFF: begin
					reg_rdata_r <= {25'h0, ae_off_r};
				end
				`DCF_REG_AF_OFF: begin
					reg_rdata_r <= {25'h0, af_off_r};
				end
				`DCF_REG_LEVEL: begin
					reg_rdata_r <= {15'h0, mark_vld_r, rt_mode_r, busy_r,
					                lvl_real, space_used};
				end
				default: begin
					reg_rdata_r <= 32'h00000000;
				end
			endcase
		end else begin
			reg_rdata_r <= 32'h00000000;
		end
	end

endmodule

/* dcf_checker.sv */
// concurrent checks on the fifo flag and latency ports
`include "dcf_defines.vh"
module dcf_checker (
	// clock and reset
	input wire               clk,
	input wire               rst_b,
	// write side
	input wire               wr_en_n,
	input wire [`DCF_DW-1:0] wr_data,
	input wire               mailbox_select,
	input wire               reg_wr,
	// read side
	input wire               rd_en_n,
	input wire               config_load_select_n,
	input wire               retransmit_request_n,
	input wire               mark_req,
	input wire [`DCF_DW-1:0] q_r,
	input wire               q_valid_r,
	// flags, partial reset and busy
	input wire               full_flag_n,
	input wire               empty_flag_n,
	input wire               almost_empty_flag_n,
	input wire               almost_full_flag_n,
	input wire               partial_reset_n,
	input wire               busy_r
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// quiet time
	// ********
	// offset writes, marks, retransmits and resets move flags on their own,
	// so the almost-empty and almost-full checks only run once those have been still for a while
	reg  [4:0] quiet_r;
	reg        rt_d_r;
	wire       calm = quiet_r > 5'h18;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			quiet_r <= 5'h00;
			rt_d_r  <= 1'b1;
		end else begin
			rt_d_r <= retransmit_request_n;
			if (busy_r || reg_wr || mark_req || !partial_reset_n
			    || (rt_d_r && !retransmit_request_n))
				quiet_r <= 5'h00;
			else if (quiet_r != 5'h1F)
				quiet_r <= quiet_r + 5'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_fifo_rd;
		!rd_en_n && config_load_select_n && empty_flag_n && !busy_r && partial_reset_n && calm;
	endsequence
	sequence s_cfg_rd;
		!rd_en_n && !config_load_select_n && !busy_r && partial_reset_n && calm;
	endsequence
	sequence s_mb_wr;
		!wr_en_n && mailbox_select && !busy_r && partial_reset_n;
	endsequence
	property p_mb;
		s_mb_wr |-> ##2 q_valid_r && q_r == $past(wr_data, 2);
	endproperty
	property p_rd;
		s_fifo_rd |-> ##4 q_valid_r;
	endproperty
	property p_cfg;
		s_cfg_rd |-> ##4 q_valid_r;
	endproperty
	property p_ef;
		$fell(empty_flag_n) && !busy_r && !$past(busy_r) |-> !$past(rd_en_n);
	endproperty
	property p_ff;
		$fell(full_flag_n) |-> !$past(wr_en_n) || !$past(wr_en_n, 2)
			|| !$past(wr_en_n, 3) || !$past(wr_en_n, 4);
	endproperty
	// a flag that moves k edges after the request edge is sampled one edge later
	property p_afl;
		$fell(almost_full_flag_n) && calm |-> !$past(wr_en_n, 6);
	endproperty
	property p_aeh;
		$rose(almost_empty_flag_n) && calm |-> !$past(wr_en_n, 6);
	endproperty
	property p_ael;
		$fell(almost_empty_flag_n) && calm |-> !$past(rd_en_n, 8);
	endproperty
	property p_afh;
		$rose(almost_full_flag_n) && calm |-> !$past(rd_en_n, 8);
	endproperty
	a_mb: assert property (p_mb)
		else $error("mailbox word late or wrong");
	a_rd: assert property (p_rd)
		else $error("read data not valid four cycles after read");
	a_cfg: assert property (p_cfg)
		else $error("config word not valid four cycles after read");
	a_ef: assert property (p_ef)
		else $error("empty flag fell without a read at that edge");
	a_ff: assert property (p_ff)
		else $error("full flag fell without a recent write");
	a_afl: assert property (p_afl)
		else $error("almost full fell not five cycles after a write");
	a_aeh: assert property (p_aeh)
		else $error("almost empty rose not five cycles after a write");
	a_ael: assert property (p_ael)
		else $error("almost empty fell not seven cycles after a read");
	a_afh: assert property (p_afh)
		else $error("almost full rose not seven cycles after a read");
endmodule

bind dcf_fifo dcf_checker u_chk (.clk, .rst_b, .wr_en_n, .wr_data, .mailbox_select, .reg_wr,
	.rd_en_n, .config_load_select_n, .retransmit_request_n, .mark_req, .q_r, .q_valid_r,
	.full_flag_n, .empty_flag_n, .almost_empty_flag_n, .almost_full_flag_n,
	.partial_reset_n, .busy_r);

/* dcf_rdr_model.sv */
// reader-side model: paces read strobes and collects every word shown
`include "dcf_defines.vh"
module dcf_rdr_model (
	// clock and reset
	input  wire               clk,
	input  wire               rst_b,
	// requests from the bench
	input  wire               rd_req,
	input  wire               cfg_req,
	// fifo read port
	input  wire               busy_r,
	input  wire               retransmit_request_n,
	input  wire [`DCF_DW-1:0] q_r,
	input  wire               q_valid_r,
	output reg                rd_en_n,
	output reg                config_load_select_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [`DCF_DW-1:0] got [$];
	reg   [4:0]         hold_r;
	reg                 rt_d_r;
	wire                rt_fall = rt_d_r && !retransmit_request_n;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_en_n              <= 1'b1;
			config_load_select_n <= 1'b1;
			hold_r               <= 5'h00;
			rt_d_r               <= 1'b1;
		end else begin
			rt_d_r <= retransmit_request_n;
			// first read lands on the 17th edge after the request is seen low
			if (rt_fall)
				hold_r <= 5'h10;
			else if (hold_r != 5'h00)
				hold_r <= hold_r - 5'h01;
			rd_en_n              <= !(rd_req && !busy_r && hold_r <= 5'h01 && !rt_fall);
			config_load_select_n <= !cfg_req;
			if (q_valid_r)
				got.push_back(q_r);
		end
	end
endmodule

/* dual_clock_fifo_latency_flags_tb_top.sv */
// self-checking bench for the fifo flag and latency block
`include "dcf_defines.vh"
module dual_clock_fifo_latency_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	reg                clk = 1'b0, rst_b = 1'b0, wr_en_n = 1'b1, mailbox_select = 1'b0;
	reg  [35:0]        wr_data = 36'h0;
	reg                retransmit_request_n = 1'b1, mark_req = 1'b0, partial_reset_n = 1'b1;
	reg  [7:0]         reg_addr = 8'h00;
	reg  [31:0]        reg_wdata = 32'h0;
	reg                reg_wr = 1'b0, reg_rd = 1'b0, rd_req = 1'b0, cfg_req = 1'b0;
	wire [35:0]        q_r;
	wire [31:0]        reg_rdata_r;
	wire               q_valid_r, full_flag_n, empty_flag_n, almost_empty_flag_n;
	wire               almost_full_flag_n, busy_r, irq_r, rd_en_n, config_load_select_n;
	int                error_cnt = 0, samples_checked = 0;
	logic [35:0]       exp_q [$];
	always #2 clk = ~clk;
	dcf_fifo uut (.clk, .rst_b, .wr_en_n, .wr_data, .mailbox_select, .rd_en_n,
		.config_load_select_n, .retransmit_request_n, .mark_req, .q_r, .q_valid_r,
		.full_flag_n, .empty_flag_n, .almost_empty_flag_n, .almost_full_flag_n,
		.partial_reset_n, .busy_r, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .irq_r);
	dcf_rdr_model rdr (.clk, .rst_b, .rd_req, .cfg_req, .busy_r, .retransmit_request_n,
		.q_r, .q_valid_r, .rd_en_n, .config_load_select_n);
	// ********
	// helpers
	// ********
	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [35:0] rnd();
		return {4'($urandom()), $urandom()};
	endfunction
	function automatic logic sig(input int w);
		case (w)
			0: return full_flag_n;
			1: return empty_flag_n;
			2: return busy_r;
			default: return q_valid_r;
		endcase
	endfunction
	// k is the edge, counted from the calling edge, at which the level first shows
	task automatic wait_sig(input int w, input logic lvl, input int lim, output int k);
		for (k = 1; k <= lim; k++) begin
			@(posedge clk);
			#1;
			if (sig(w) === lvl)
				break;
		end
		@(posedge clk);
	endtask
	task automatic wr(input logic [35:0] d, input logic mb);
		wr_en_n        <= 1'b0;
		wr_data        <= d;
		mailbox_select <= mb;
		@(posedge clk);
		if (mb)
			exp_q.push_front(d);
		else
			exp_q.push_back(d);
	endtask
	task automatic wr_end;
		wr_en_n        <= 1'b1;
		mailbox_select <= 1'b0;
	endtask
	task automatic rd(input int n, input logic c);
		rd_req  <= 1'b1;
		cfg_req <= c;
		tick(n);
		rd_req  <= 1'b0;
		cfg_req <= 1'b0;
	endtask
	task automatic drain;
		for (int i = 0; i < 300 && rdr.got.size() < exp_q.size(); i++)
			@(posedge clk);
		while (exp_q.size() > 0)
			check("q_r", rdr.got.size() ? rdr.got.pop_front() : 'X, exp_q.pop_front());
	endtask
	task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata_r;
		@(posedge clk);
	endtask
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
	// ********
	// scenarios
	// ********
	initial begin
		int k, k2, n;
		logic [31:0] d;
		logic [35:0] hist [$];
		void'($urandom(91234));
		tick(5);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
		check("full_rst", full_flag_n, 1'b1);
		check("empty_rst", empty_flag_n, 1'b0);
		check("ae_rst", almost_empty_flag_n, 1'b0);
		check("af_rst", almost_full_flag_n, 1'b1);
		wait_sig(2, 1'b0, 40, k);
		reg_rd_t(`DCF_REG_IRQ_EN, d);
		check("irq_en_rst", d, `DCF_IRQ_EN_RST);
		reg_rd_t(`DCF_REG_AE_OFF, d);
		check("ae_off_rst", d, `DCF_AE_OFF_RST);
		reg_rd_t(8'hFC, d);
		check("unmapped", d, 0);
		// one word into an empty fifo
		wr(rnd(), 1'b0);
		wr_end();
		wait_sig(1, 1'b1, 30, k);
		check("ef_release", k <= 24, 1);
		rd(1, 1'b0);
		drain();
		// reads chasing writes, then a mailbox word overtaking stored words
		for (int r = 0; r < 3; r++) begin
			n = $urandom_range(20, 1);
			fork
				begin
					for (int i = 0; i < n; i++)
						wr(rnd(), 1'b0);
					wr_end();
				end
				begin
					tick(3);
					rd(n, 1'b0);
				end
			join
			drain();
		end
		for (int i = 0; i < 3; i++)
			wr(rnd(), 1'b0);
		wr(rnd(), 1'b1);
		wr_end();
		tick(4);
		rd(3, 1'b0);
		drain();
		// fill to full, overflow, release
		for (int i = 0; i < 64; i++)
			wr(rnd(), 1'b0);
		wr_end();
		wait_sig(0, 1'b0, 6, k);
		check("ff_assert", k <= 4, 1);
		tick(6);
		check("af_low", almost_full_flag_n, 1'b0);
		check("ae_high", almost_empty_flag_n, 1'b1);
		wr(rnd(), 1'b0);
		wr_end();
		void'(exp_q.pop_back());
		rd(1, 1'b0);
		@(posedge clk);
		wait_sig(0, 1'b1, 12, k);
		check("ff_release", k, 8);
		rd(63, 1'b0);
		drain();
		tick(10);
		check("empty_low", empty_flag_n, 1'b0);
		check("ae_low", almost_empty_flag_n, 1'b0);
		check("af_high", almost_full_flag_n, 1'b1);
		// overflow event, masked then enabled then cleared
		check("irq_masked", irq_r, 1'b0);
		reg_wr_t(`DCF_REG_IRQ_EN, 32'h10);
		tick(2);
		check("irq_on", irq_r, 1'b1);
		reg_rd_t(`DCF_REG_STATUS, d);
		check("ovf_bit", d[`DCF_EV_OVF], 1'b1);
		reg_wr_t(`DCF_REG_IRQ_CLR, 32'h10);
		tick(2);
		check("irq_off", irq_r, 1'b0);
		// mark, read out, retransmit
		tick(30);
		mark_req <= 1'b1;
		@(posedge clk);
		mark_req <= 1'b0;
		for (int i = 0; i < 4; i++)
			wr(rnd(), 1'b0);
		wr_end();
		// mark valid, four words held, space counted from the mark
		reg_rd_t(`DCF_REG_LEVEL, d);
		check("level", d, 32'h00010204);
		hist = exp_q;
		rd(4, 1'b0);
		drain();
		exp_q = hist;
		retransmit_request_n <= 1'b0;
		@(posedge clk);
		fork
			wait_sig(3, 1'b1, 30, k);
			wait_sig(1, 1'b1, 30, k2);
			begin
				tick(4);
				retransmit_request_n <= 1'b1;
				tick(11);
				rd(4, 1'b0);
			end
		join
		check("rt_data", k <= 21, 1);
		check("rt_flags", k2 <= 17, 1);
		drain();
		// configuration words
		n = $urandom_range(20, 1);
		reg_wr_t(`DCF_REG_AE_OFF, n);
		tick(30);
		rd(2, 1'b1);
		tick(8);
		check("cfg0", rdr.got.pop_front() & 36'h7F, n);
		check("cfg1", rdr.got.pop_front() & 36'h7F, `DCF_AF_OFF_RST);
		// partial reset drops stored words and holds off for a while
		for (int i = 0; i < 3; i++)
			wr(rnd(), 1'b0);
		wr_end();
		exp_q.delete();
		partial_reset_n <= 1'b0;
		tick(2);
		partial_reset_n <= 1'b1;
		wait_sig(2, 1'b0, 40, k);
		check("prs_busy", k inside {[32:33]}, 1);
		check("prs_empty", empty_flag_n, 1'b0);
		wr(rnd(), 1'b0);
		wr_end();
		tick(2);
		rd(1, 1'b0);
		drain();
		tally_and_finish();
	end
endmodule
